// >>> core/dsc_pkg.sv
// Behaviour
// - Both differential enables are off after reset.
// - Software writes the configuration; it applies at once.
// - Read and data strobe enables are independent bits.
// - Complement used only in DDR mode with enable.
// - Capability register reports differential support per strobe.
// - Full reset clears enables in second generation mode.
// - Full reset keeps enables in third generation mode.
// - Synchronous and unit resets leave enables untouched.
package dsc_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_CAPS = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ==========================================================================
  // Field positions.
  localparam int BIT_READ_DIFF = 0;
  localparam int BIT_DATA_DIFF = 1;
  localparam int BIT_SETTLE_PENDING = 2;
  localparam int MODE_LSB = 0;
  localparam int MODE_WIDTH = 2;
  localparam int CMD_WIDTH = 8;

  // ==========================================================================
  // Reset values.
  localparam logic [1:0] RST_DIFF_EN = 2'h0;
  localparam logic [1:0] RST_MODE = 2'h0;

  // ==========================================================================
  // Interface mode codes.
  localparam logic [1:0] MODE_SINGLE_RATE = 2'h0;
  localparam logic [1:0] MODE_DDR_SECOND_GEN = 2'h1;
  localparam logic [1:0] MODE_DDR_THIRD_GEN = 2'h2;

  // ==========================================================================
  // Reset command codes.
  localparam logic [7:0] CMD_FULL_RESET = 8'hFF;
  localparam logic [7:0] CMD_SYNC_RESET = 8'hFC;
  localparam logic [7:0] CMD_UNIT_RESET = 8'hFA;

  // ==========================================================================
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> core/dsc_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change is passed on once stages two and three
// agree, so a single-stage glitch never reaches the output.
module dsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_q;

  // Per bit, accept the value only where the two late stages agree.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_q[i] = (stage2[i] == stage3[i]) ? stage3[i] : q[i];
    end
  end

  // Shift the chain and hold the filtered output.
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
      q <= next_q;
    end
  end

endmodule // dsc_sync

// >>> core/dsc_ctrl.sv
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module dsc_ctrl #(
  parameter logic SUPPORT_READ_DIFF = 1'b1,
  parameter logic SUPPORT_DATA_DIFF = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host chip enable pin, active low.
  input wire logic chipEnable_n,
  // Link side, on the link clock.
  input wire logic linkClk,
  input wire logic linkReset,
  input wire logic read_strobe_true,
  input wire logic read_strobe_complement,
  output logic readStrobeLevel,
  input wire logic dataStrobeDrive,
  output logic dataStrobeTrue,
  output logic dataStrobeComplement,
  output logic dataStrobeComplementOe
);

  // ==========================================================================
  // Register state.
  logic [1:0] diffEn;
  logic [1:0] next_diffEn;
  logic [1:0] ifMode;
  logic [1:0] next_ifMode;
  logic settlePending;
  logic next_settlePending;
  logic [1:0] diffActive;
  logic [1:0] next_diffActive;
  logic [1:0] supportMask;
  logic ddrSelected;
  logic chipEnableHigh;

  // ==========================================================================
  // Bus slave state.
  logic awHeld;
  logic next_awHeld;
  logic [7:0] awAddrReg;
  logic [7:0] next_awAddrReg;
  logic wHeld;
  logic next_wHeld;
  logic [31:0] wDataReg;
  logic [31:0] next_wDataReg;
  logic [3:0] wStrbReg;
  logic [3:0] next_wStrbReg;
  logic next_awReady;
  logic next_wReady;
  logic next_bValid;
  logic [1:0] next_bResp;
  logic next_arReady;
  logic next_rValid;
  logic [31:0] next_rData;
  logic [1:0] next_rResp;
  logic awFire;
  logic wFire;
  logic doWrite;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;

  assign supportMask = {SUPPORT_DATA_DIFF, SUPPORT_READ_DIFF};
  assign ddrSelected = (ifMode == dsc_pkg::MODE_DDR_SECOND_GEN) ||
                       (ifMode == dsc_pkg::MODE_DDR_THIRD_GEN);

  // Chip enable comes from a pin and is synchronised before use.
  dsc_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_ce_sync (
    .clk(ref_clk),
    .reset(reset),
    .d(chipEnable_n),
    .q(chipEnableHigh)
  );

  // ==========================================================================
  // Write channel: address and data are taken in either order.
  assign awFire = s_axi_awvalid && s_axi_awready;
  assign wFire = s_axi_wvalid && s_axi_wready;
  assign wrAddr = awHeld ? awAddrReg : s_axi_awaddr;
  assign wrData = wHeld ? wDataReg : s_axi_wdata;
  assign wrStrb = wHeld ? wStrbReg : s_axi_wstrb;
  assign doWrite = (awHeld || awFire) && (wHeld || wFire) && !s_axi_bvalid;

  // Holding registers and write response.
  always_comb begin
    next_awHeld = awHeld;
    next_awAddrReg = awAddrReg;
    next_wHeld = wHeld;
    next_wDataReg = wDataReg;
    next_wStrbReg = wStrbReg;
    next_bValid = s_axi_bvalid;
    next_bResp = s_axi_bresp;
    if (awFire) begin
      next_awHeld = 1'b1;
      next_awAddrReg = s_axi_awaddr;
    end
    if (wFire) begin
      next_wHeld = 1'b1;
      next_wDataReg = s_axi_wdata;
      next_wStrbReg = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      unique case (wrAddr)
        dsc_pkg::OFS_CONFIG, dsc_pkg::OFS_MODE,
        dsc_pkg::OFS_COMMAND: next_bResp = dsc_pkg::RESP_OKAY;
        default: next_bResp = dsc_pkg::RESP_SLVERR;
      endcase
    end
    next_awReady = !next_awHeld && !next_bValid;
    next_wReady = !next_wHeld && !next_bValid;
  end

  // ==========================================================================
  // Configuration, mode and reset commands.
  always_comb begin
    next_diffEn = diffEn;
    next_ifMode = ifMode;
    next_settlePending = settlePending;
    // A high chip enable ends the settling wait after a change.
    if (chipEnableHigh) begin
      next_settlePending = 1'b0;
    end
    if (doWrite && wrStrb[0]) begin
      unique case (wrAddr)
        dsc_pkg::OFS_CONFIG: begin
          // Each strobe has its own bit; unsupported ones stay off.
          next_diffEn = wrData[1:0] & supportMask;
        end
        dsc_pkg::OFS_MODE: begin
          next_ifMode = wrData[dsc_pkg::MODE_LSB +: dsc_pkg::MODE_WIDTH];
        end
        dsc_pkg::OFS_COMMAND: begin
          unique case (wrData[dsc_pkg::CMD_WIDTH-1:0])
            dsc_pkg::CMD_FULL_RESET: begin
              if (ifMode == dsc_pkg::MODE_DDR_SECOND_GEN) begin
                next_diffEn = dsc_pkg::RST_DIFF_EN;
              end else begin
                next_diffEn = diffEn;
              end
            end
            dsc_pkg::CMD_SYNC_RESET, dsc_pkg::CMD_UNIT_RESET: begin
              next_diffEn = diffEn;
            end
            default: next_diffEn = diffEn;
          endcase
        end
        default: next_diffEn = diffEn;
      endcase
    end
    // A change of setting opens the wait; it wins over a clear.
    if (next_diffEn != diffEn) begin
      next_settlePending = 1'b1;
    end
    // Complement pins are used only in a DDR mode with the enable set.
    next_diffActive = ddrSelected ? diffEn : 2'h0;
  end

  // ==========================================================================
  // Read channel.
  always_comb begin
    next_rValid = s_axi_rvalid;
    next_rData = s_axi_rdata;
    next_rResp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rResp = dsc_pkg::RESP_OKAY;
      next_rData = 32'h0000_0000;
      unique case (s_axi_araddr)
        dsc_pkg::OFS_CONFIG: next_rData[1:0] = diffEn;
        dsc_pkg::OFS_MODE: next_rData[1:0] = ifMode;
        dsc_pkg::OFS_COMMAND: next_rData = 32'h0000_0000;
        dsc_pkg::OFS_CAPS: next_rData[1:0] = supportMask;
        dsc_pkg::OFS_STATUS: begin
          next_rData[dsc_pkg::BIT_READ_DIFF] =
            diffActive[dsc_pkg::BIT_READ_DIFF];
          next_rData[dsc_pkg::BIT_DATA_DIFF] =
            diffActive[dsc_pkg::BIT_DATA_DIFF];
          next_rData[dsc_pkg::BIT_SETTLE_PENDING] = settlePending;
        end
        default: next_rResp = dsc_pkg::RESP_SLVERR;
      endcase
    end
    next_arReady = !next_rValid;
  end

  // Register stage for the whole bus-side state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      diffEn <= dsc_pkg::RST_DIFF_EN;
      ifMode <= dsc_pkg::RST_MODE;
      settlePending <= 1'b0;
      diffActive <= dsc_pkg::RST_DIFF_EN;
      awHeld <= 1'b0;
      awAddrReg <= 8'h00;
      wHeld <= 1'b0;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dsc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dsc_pkg::RESP_OKAY;
    end else begin
      diffEn <= next_diffEn;
      ifMode <= next_ifMode;
      settlePending <= next_settlePending;
      diffActive <= next_diffActive;
      awHeld <= next_awHeld;
      awAddrReg <= next_awAddrReg;
      wHeld <= next_wHeld;
      wDataReg <= next_wDataReg;
      wStrbReg <= next_wStrbReg;
      s_axi_awready <= next_awReady;
      s_axi_wready <= next_wReady;
      s_axi_bvalid <= next_bValid;
      s_axi_bresp <= next_bResp;
      s_axi_arready <= next_arReady;
      s_axi_rvalid <= next_rValid;
      s_axi_rdata <= next_rData;
      s_axi_rresp <= next_rResp;
    end
  end

  // ==========================================================================
  // Link domain.
  logic [1:0] linkActive;
  logic [1:0] linkStrobe;
  logic next_readStrobeLevel;
  logic next_dataStrobeTrue;
  logic next_dataStrobeComplement;
  logic next_dataStrobeComplementOe;

  // The active flags are levels and cross into the link domain.
  dsc_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h0)
  ) u_active_sync (
    .clk(linkClk),
    .reset(linkReset),
    .d(diffActive),
    .q(linkActive)
  );

  // The read strobe pair arrives from pins; reset matches the idle pair.
  dsc_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h1)
  ) u_strobe_sync (
    .clk(linkClk),
    .reset(linkReset),
    .d({read_strobe_complement, read_strobe_true}),
    .q(linkStrobe)
  );

  // Read strobe receive and data strobe transmit per the active flags.
  always_comb begin
    if (linkActive[dsc_pkg::BIT_READ_DIFF]) begin
      // Differential: level follows the true pin while the pair is opposite.
      if (linkStrobe[0] != linkStrobe[1]) begin
        next_readStrobeLevel = linkStrobe[0];
      end else begin
        next_readStrobeLevel = readStrobeLevel;
      end
    end else begin
      next_readStrobeLevel = linkStrobe[0];
    end
    next_dataStrobeTrue = dataStrobeDrive;
    next_dataStrobeComplementOe = linkActive[dsc_pkg::BIT_DATA_DIFF];
    if (linkActive[dsc_pkg::BIT_DATA_DIFF]) begin
      next_dataStrobeComplement = !dataStrobeDrive;
    end else begin
      next_dataStrobeComplement = 1'b0;
    end
  end

  // Register stage for the link outputs.
  always_ff @(posedge linkClk) begin
    if (linkReset) begin
      readStrobeLevel <= 1'b1;
      dataStrobeTrue <= 1'b0;
      dataStrobeComplement <= 1'b0;
      dataStrobeComplementOe <= 1'b0;
    end else begin
      readStrobeLevel <= next_readStrobeLevel;
      dataStrobeTrue <= next_dataStrobeTrue;
      dataStrobeComplement <= next_dataStrobeComplement;
      dataStrobeComplementOe <= next_dataStrobeComplementOe;
    end
  end

endmodule // dsc_ctrl

// >>> verification/dsc_ctrl_sva.sv
`timescale 1ns/1ps
// ===========================================================
// Pin-level checks on the strobe control block.
module dsc_ctrl_sva (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic linkClk,
  input wire logic linkReset,
  input wire logic dataStrobeDrive,
  input wire logic dataStrobeTrue,
  input wire logic dataStrobeComplement,
  input wire logic dataStrobeComplementOe
);
  // Register bus answers, refusals and held responses.
  b_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("no write response");
  b_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  aw_refuse_a: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  r_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  r_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  r_unmapped_a: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_arvalid && s_axi_arready && s_axi_araddr > dsc_pkg::OFS_STATUS
    |=> s_axi_rresp == dsc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  ar_refuse_a: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  // Link side strobe outputs.
  ds_true_a: assert property (@(posedge linkClk) disable iff (linkReset)
    !$past(linkReset) |-> dataStrobeTrue == $past(dataStrobeDrive))
    else $error("true strobe not one cycle behind");
  ds_pair_a: assert property (@(posedge linkClk) disable iff (linkReset)
    dataStrobeComplementOe |-> dataStrobeComplement != dataStrobeTrue)
    else $error("complement not inverse");
  ds_idle_a: assert property (@(posedge linkClk) disable iff (linkReset)
    !dataStrobeComplementOe |-> !dataStrobeComplement)
    else $error("complement driven while off");
  // Main scenarios reached.
  wr_c: cover property (@(posedge ref_clk) s_axi_bvalid && s_axi_bready);
  rd_c: cover property (@(posedge ref_clk) s_axi_rvalid && s_axi_rready);
  oe_c: cover property (@(posedge linkClk) $rose(dataStrobeComplementOe));
endmodule // dsc_ctrl_sva

// >>> verification/dsc_host_model.sv
`timescale 1ns/1ps
// ===========================================================
// Host side of the link: read strobe pair and chip enable.
module dsc_host_model (
  input wire logic linkClk,
  input wire logic wantLevel,
  input wire logic wantSkew,
  input wire logic wantDeselect,
  output logic read_strobe_true,
  output logic read_strobe_complement,
  output logic chipEnable_n
);
  // Pins start idle with the device deselected.
  initial begin
    read_strobe_true = 1'b1;
    read_strobe_complement = 1'b0;
    chipEnable_n = 1'b1;
  end
  // Skew makes both pins equal, a pair the receiver must not trust.
  always @(posedge linkClk) begin
    read_strobe_true <= wantLevel;
    read_strobe_complement <= wantSkew ? wantLevel : !wantLevel;
    chipEnable_n <= wantDeselect;
  end
endmodule // dsc_host_model

// >>> verification/dsc_ctrl_tb.sv
`timescale 1ns/1ps
// ===========================================================
// Self-checking bench for the strobe control block.
module dsc_ctrl_tb;
  logic ref_clk = 1'b0, reset = 1'b1, linkClk = 1'b0, linkReset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic chipEnable_n, read_strobe_true, read_strobe_complement;
  logic readStrobeLevel, dataStrobeTrue, dataStrobeComplement;
  logic dataStrobeComplementOe;
  logic dataStrobeDrive = 1'b0, wantLevel = 1'b0, wantSkew = 1'b0;
  logic wantDeselect = 1'b1;
  int fails = 0, testsRun = 0;

  dsc_ctrl i_dut (.*);
  dsc_host_model i_host (.*);

  // Clocks: link rising edges fall between bus clock rising edges.
  always #2.5 ref_clk = !ref_clk;
  always #15 linkClk = !linkClk;
  // Data strobe pattern toggles every link cycle out of reset.
  always @(posedge linkClk) dataStrobeDrive <= !linkReset && !dataStrobeDrive;

  task automatic printVerdict();
    if (fails == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic lim(input logic stuck);
    if (stuck) begin
      $display("unexpected wait: expected answer, seen none");
      fails++;
      printVerdict();
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w, got, ok;
    logic [1:0] eb;
    aw = 1'b1;
    w = 1'b1;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && (aw || w); n++) begin
      @(posedge ref_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    lim(aw || w);
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge ref_clk);
      got = s_axi_bvalid;
    end
    lim(!got);
    // Only the writable registers answer with an okay response.
    ok = a == dsc_pkg::OFS_CONFIG || a == dsc_pkg::OFS_MODE ||
         a == dsc_pkg::OFS_COMMAND;
    eb = ok ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
    chk("bresp", {30'h0, eb}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge ref_clk);
      got = s_axi_arready;
    end
    lim(!got);
    s_axi_arvalid <= 1'b0;
    got = 1'b0;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge ref_clk);
      got = s_axi_rvalid;
    end
    lim(!got);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", {30'h0, dsc_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  // Lets pin changes pass the synchronisers in both domains.
  task automatic lw();
    repeat (10) @(posedge linkClk);
    @(posedge ref_clk);
  endtask

  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0] r;
    rc(dsc_pkg::OFS_CONFIG, 32'h0, "config");
    rc(dsc_pkg::OFS_MODE, 32'h0, "mode");
    wr(dsc_pkg::OFS_CAPS, 32'h0);
    rc(dsc_pkg::OFS_CAPS, 32'h3, "caps");
    rd(8'h40, d, r);
    chk("unmapped resp", {30'h0, dsc_pkg::RESP_SLVERR}, {30'h0, r});
  endtask

  task automatic t_enables();
    wantDeselect <= 1'b0;
    lw();
    wr(dsc_pkg::OFS_CONFIG, 32'h1);
    rc(dsc_pkg::OFS_CONFIG, 32'h1, "read enable only");
    rc(dsc_pkg::OFS_STATUS, 32'h4, "settle pending");
    wantDeselect <= 1'b1;
    lw();
    rc(dsc_pkg::OFS_STATUS, 32'h0, "settled");
    wr(dsc_pkg::OFS_CONFIG, 32'h2);
    rc(dsc_pkg::OFS_CONFIG, 32'h2, "data enable only");
    // A write with the low byte strobe off leaves the setting alone.
    s_axi_wstrb <= 4'hE;
    wr(dsc_pkg::OFS_CONFIG, 32'h0);
    s_axi_wstrb <= 4'hF;
    rc(dsc_pkg::OFS_CONFIG, 32'h2, "strobe off");
  endtask

  task automatic t_active();
    logic act;
    for (int m = 0; m < 4; m++) begin
      act = m[1:0] == dsc_pkg::MODE_DDR_SECOND_GEN ||
            m[1:0] == dsc_pkg::MODE_DDR_THIRD_GEN;
      wr(dsc_pkg::OFS_MODE, {30'h0, dsc_pkg::MODE_SINGLE_RATE});
      wr(dsc_pkg::OFS_CONFIG, 32'h3);
      wr(dsc_pkg::OFS_MODE, {30'h0, m[1:0]});
      wantLevel <= 1'b0;
      wantSkew <= 1'b0;
      lw();
      wantLevel <= 1'b1;
      wantSkew <= 1'b1;
      lw();
      rc(dsc_pkg::OFS_STATUS, act ? 32'h3 : 32'h0, "active");
      chk("oe", {31'h0, act}, {31'h0, dataStrobeComplementOe});
      chk("read level", {31'h0, !act}, {31'h0, readStrobeLevel});
    end
    // DDR with only the data enable: read pins equal, level follows true.
    wr(dsc_pkg::OFS_MODE, {30'h0, dsc_pkg::MODE_SINGLE_RATE});
    wr(dsc_pkg::OFS_CONFIG, 32'h2);
    wr(dsc_pkg::OFS_MODE, {30'h0, dsc_pkg::MODE_DDR_THIRD_GEN});
    wantLevel <= 1'b0;
    lw();
    chk("read level off", 32'h0, {31'h0, readStrobeLevel});
    chk("oe data only", 32'h1, {31'h0, dataStrobeComplementOe});
  endtask

  task automatic t_resets();
    logic [7:0] cmds [3];
    logic clr;
    cmds = '{dsc_pkg::CMD_FULL_RESET, dsc_pkg::CMD_SYNC_RESET,
             dsc_pkg::CMD_UNIT_RESET};
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 3; c++) begin
        clr = m[1:0] == dsc_pkg::MODE_DDR_SECOND_GEN &&
              cmds[c] == dsc_pkg::CMD_FULL_RESET;
        wr(dsc_pkg::OFS_MODE, {30'h0, dsc_pkg::MODE_SINGLE_RATE});
        wr(dsc_pkg::OFS_CONFIG, 32'h3);
        wr(dsc_pkg::OFS_MODE, {30'h0, m[1:0]});
        wr(dsc_pkg::OFS_COMMAND, {24'h0, cmds[c]});
        rc(dsc_pkg::OFS_CONFIG, clr ? 32'h0 : 32'h3, "kept");
      end
    end
  endtask

  // Link reset is held long enough to flush its synchronisers.
  initial begin
    repeat (6) @(posedge linkClk);
    linkReset <= 1'b0;
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_defaults();
    lw();
    t_enables();
    t_active();
    t_resets();
    printVerdict();
  end
endmodule // dsc_ctrl_tb

bind dsc_ctrl dsc_ctrl_sva i_sva (.*);
